// ==== obcd_pkg.sv ====
// package: option byte addresses, register indices, field layout, reset values and shared types
package obcd_pkg;

	// option byte locations in memory
	localparam int              OBCD_MEM_ADDR_W     = 20;
	localparam logic [19:0]     OBCD_BASE_PRIMARY   = 20'h0_00c0;
	localparam logic [19:0]     OBCD_BASE_SWAP      = 20'h0_20c0;
	localparam logic [1:0]      OBCD_LAST_BYTE      = 2'h3;

	// register indices on the bus; byte address is four times the index
	localparam int              OBCD_BUS_ADDR_W     = 10;
	localparam logic [7:0]      OBCD_IDX_CTRL       = 8'h00;
	localparam logic [7:0]      OBCD_IDX_STATUS     = 8'h01;
	localparam logic [7:0]      OBCD_IDX_WDT        = 8'hc0;
	localparam logic [7:0]      OBCD_IDX_CLKRST     = 8'hc1;
	localparam logic [7:0]      OBCD_IDX_CLKOUT     = 8'hc2;
	localparam logic [7:0]      OBCD_IDX_DEBUG      = 8'hc3;

	// watchdog byte fields
	localparam int              OBCD_WDT_STBY_BIT   = 0;
	localparam int              OBCD_WDT_WIN_LSB    = 5;
	localparam logic [1:0]      OBCD_WIN_FULL       = 2'h3;

	// clock and reset byte fields
	localparam int              OBCD_CR_SLOW_EN     = 7;
	localparam int              OBCD_CR_SLOW_STOP   = 6;
	localparam int              OBCD_CR_SLOW_SYSBLK = 5;
	localparam int              OBCD_CR_CLKMON_DIS  = 4;
	localparam int              OBCD_CR_PIN_FUNC    = 3;
	localparam int              OBCD_CR_LOOP_SEL    = 2;
	localparam int              OBCD_CR_FAST_4M     = 1;
	localparam int              OBCD_CR_VDET_OFF    = 0;
	localparam logic [3:0]      OBCD_MULT_EIGHT     = 4'h8;
	localparam logic [3:0]      OBCD_MULT_SIX       = 4'h6;

	// clock output byte fields
	localparam int              OBCD_CO_DEF_DIS     = 7;
	localparam int              OBCD_CO_FIXED_LSB   = 5;
	localparam logic [1:0]      OBCD_CO_FIXED_VAL   = 2'h3;
	localparam logic [1:0]      OBCD_SRC_MAIN       = 2'h3;
	localparam logic [1:0]      OBCD_SRC_LOOP       = 2'h2;
	localparam logic [1:0]      OBCD_SRC_SLOW       = 2'h1;
	localparam logic [1:0]      OBCD_SRC_SUB        = 2'h0;
	localparam int              OBCD_CLKOUT_CNT_W   = 14;

	// debug byte fields
	localparam int              OBCD_DBG_EN_BIT     = 7;
	localparam int              OBCD_DBG_KEEP_BIT   = 0;
	localparam logic [5:0]      OBCD_DBG_FIXED_VAL  = 6'h02;
	localparam logic [1:0]      OBCD_DBG_OFF        = 2'h0;
	localparam logic [1:0]      OBCD_DBG_BAD        = 2'h1;
	localparam logic [1:0]      OBCD_DBG_ERASE      = 2'h2;
	localparam logic [1:0]      OBCD_DBG_KEEP       = 2'h3;

	// control register bits and reset values
	localparam int              OBCD_CTRL_VDET_RUN  = 0;
	localparam int              OBCD_CTRL_CLKOUT_EN = 1;
	localparam int              OBCD_CTRL_LATCH     = 2;
	localparam logic [7:0]      OBCD_BYTE_RST       = 8'h00;

	// the four option bytes as fetched
	typedef struct packed {
		logic [7:0] debug;
		logic [7:0] clkout;
		logic [7:0] clkrst;
		logic [7:0] wdt;
	} obcd_opt_bytes_t;

	// status register layout
	typedef struct packed {
		logic [1:0] rsvd;
		logic       debug_fixed_bad;
		logic       debug_prohibited;
		logic       clkout_fixed_bad;
		logic       clkout_sel_bad;
		logic       swap_used;
		logic       load_done;
	} obcd_status_t;

endpackage

// ==== obcd_decoder.sv ====
// option byte loader and decoder with its avalon register slave
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps

module obcd_decoder (
	input  logic                                 clk,
	input  logic                                 reset_n,
	input  logic                                 boot_swap,
	input  logic                                 halt_mode,
	input  logic                                 stop_mode,
	input  logic                                 flash_prog_mode,
	input  logic                                 main_tick,
	input  logic                                 loop_tick,
	input  logic                                 slow_tick,
	input  logic                                 sub_tick,
	output logic                                 mem_rd_req,
	output logic [obcd_pkg::OBCD_MEM_ADDR_W-1:0] mem_addr,
	input  logic [7:0]                           mem_rd_data,
	input  logic                                 mem_rd_valid,
	input  logic [obcd_pkg::OBCD_BUS_ADDR_W-1:0] avs_address,
	input  logic                                 avs_read,
	input  logic                                 avs_write,
	input  logic [31:0]                          avs_writedata,
	input  logic [3:0]                           avs_byteenable,
	output logic [31:0]                          avs_readdata,
	output logic                                 avs_waitrequest,
	output logic                                 cfg_done,
	output logic                                 wdt_count_enable,
	output logic                                 watchdog_standby_run,
	output logic [1:0]                           watchdog_window,
	output logic                                 slow_osc_run,
	output logic                                 slow_osc_sysclk_allowed,
	output logic                                 clock_monitor_enable,
	output logic                                 shared_output_pin,
	output logic [3:0]                           loop_multiplier,
	output logic                                 fast_osc_4mhz,
	output logic                                 low_voltage_detector_enable,
	output logic                                 clock_output_pin,
	output logic                                 debug_enable,
	output logic                                 debug_erase_on_fail
);

	// loader states, one-hot
	typedef enum logic [3:0] {
		OBCD_ST_FETCH  = 4'b0001,
		OBCD_ST_WAIT   = 4'b0010,
		OBCD_ST_COMMIT = 4'b0100,
		OBCD_ST_DONE   = 4'b1000
	} obcd_state_t;

	// divider exponent for the low three source bits
	function automatic logic [3:0] obcd_div_exp(input logic [2:0] sel);
		logic [3:0] e;
		e = 4'h0;
		unique case (sel)
			3'h7: e = 4'h0;
			3'h6: e = 4'h1;
			3'h5: e = 4'h2;
			3'h4: e = 4'h3;
			3'h3: e = 4'h4;
			3'h2: e = 4'hb;
			3'h1: e = 4'hc;
			3'h0: e = 4'hd;
		endcase
		return e;
	endfunction

	obcd_state_t                state_ff;              // loader state
	logic [1:0]                 byte_idx_ff;           // byte being fetched
	logic [19:0]                base_ff;               // base address taken at load start
	logic                       swap_ff;               // boot swap seen at load start
	obcd_pkg::obcd_opt_bytes_t  raw_ff;                // bytes as fetched
	obcd_pkg::obcd_opt_bytes_t  opt_ff;                // bytes committed
	logic                       mem_rd_req_ff;         // memory read strobe
	logic [19:0]                mem_addr_ff;           // memory read address
	logic [7:0]                 ctrl_ff;               // software control register
	obcd_pkg::obcd_status_t     status_ff;             // status register
	logic                       waitreq_ff;            // avalon wait request
	logic [31:0]                readdata_ff;           // avalon read data
	logic [31:0]                nxt_readdata;          // read data mux
	logic [7:0]                 bus_idx;               // word index on the bus
	logic                       wr_take;               // write takes effect now
	logic                       done_ff;               // configuration committed
	logic                       wdt_cnt_en_ff;
	logic                       wdt_stby_ff;
	logic [1:0]                 wdt_win_ff;
	logic                       slow_run_ff;
	logic                       slow_sys_ff;
	logic                       clkmon_ff;
	logic                       pin_ff;
	logic [3:0]                 mult_ff;
	logic                       fast4_ff;
	logic                       vdet_en_ff;
	logic                       dbg_en_ff;
	logic                       dbg_erase_ff;
	logic [3:0]                 co_exp_ff;             // committed divider exponent
	logic [1:0]                 co_src_ff;             // committed output source
	logic                       co_valid_ff;           // committed selection is legal
	logic [13:0]                co_cnt_ff;             // output clock divider
	logic                       co_pin_ff;             // output clock level
	logic                       co_tick;               // selected source tick
	logic                       co_run;                // output clock running

	assign bus_idx = avs_address[obcd_pkg::OBCD_BUS_ADDR_W-1:2];
	assign wr_take = avs_write && !waitreq_ff && avs_byteenable[0];

	// loader sequence after every reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff      <= OBCD_ST_FETCH;
			byte_idx_ff   <= 2'h0;
			mem_rd_req_ff <= 1'b0;
			mem_addr_ff   <= 20'h0_0000;
			raw_ff        <= '0;
			base_ff       <= obcd_pkg::OBCD_BASE_PRIMARY;
			swap_ff       <= 1'b0;
		end else begin
			mem_rd_req_ff <= 1'b0;
			unique case (state_ff)
				OBCD_ST_FETCH: begin
					// alternate copy when boot swap is active
					if (byte_idx_ff == 2'h0) begin
						base_ff <= boot_swap ? obcd_pkg::OBCD_BASE_SWAP
						                     : obcd_pkg::OBCD_BASE_PRIMARY;
						swap_ff <= boot_swap;
						mem_addr_ff <= (boot_swap ? obcd_pkg::OBCD_BASE_SWAP
						                          : obcd_pkg::OBCD_BASE_PRIMARY);
					end else begin
						mem_addr_ff <= base_ff + {18'h0_0000, byte_idx_ff};
					end
					mem_rd_req_ff <= 1'b1;
					state_ff      <= OBCD_ST_WAIT;
				end
				OBCD_ST_WAIT: begin
					// capture the byte, then fetch next or commit
					if (mem_rd_valid) begin
						raw_ff[8*byte_idx_ff +: 8] <= mem_rd_data;
						if (byte_idx_ff == obcd_pkg::OBCD_LAST_BYTE) begin
							state_ff <= OBCD_ST_COMMIT;
						end else begin
							byte_idx_ff <= byte_idx_ff + 2'h1;
							state_ff    <= OBCD_ST_FETCH;
						end
					end
				end
				OBCD_ST_COMMIT: begin
					state_ff <= OBCD_ST_DONE;
				end
				OBCD_ST_DONE: begin
					state_ff <= OBCD_ST_DONE;
				end
				default: begin
					state_ff <= OBCD_ST_FETCH;
				end
			endcase
		end
	end

	// static decode, all updated together at commit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			opt_ff       <= '0;
			done_ff      <= 1'b0;
			wdt_stby_ff  <= 1'b0;
			wdt_win_ff   <= obcd_pkg::OBCD_WIN_FULL;
			slow_sys_ff  <= 1'b0;
			clkmon_ff    <= 1'b0;
			mult_ff      <= obcd_pkg::OBCD_MULT_EIGHT;
			fast4_ff     <= 1'b0;
			dbg_en_ff    <= 1'b0;
			dbg_erase_ff <= 1'b0;
			co_exp_ff    <= 4'h0;
			co_src_ff    <= obcd_pkg::OBCD_SRC_MAIN;
			co_valid_ff  <= 1'b0;
		end else if (state_ff == OBCD_ST_COMMIT) begin
			opt_ff      <= raw_ff;
			done_ff     <= 1'b1;
			wdt_stby_ff <= raw_ff.wdt[obcd_pkg::OBCD_WDT_STBY_BIT];
			// standby bit clear means full window whatever the field says
			wdt_win_ff  <= raw_ff.wdt[obcd_pkg::OBCD_WDT_STBY_BIT]
			             ? raw_ff.wdt[obcd_pkg::OBCD_WDT_WIN_LSB +: 2]
			             : obcd_pkg::OBCD_WIN_FULL;
			slow_sys_ff <= !raw_ff.clkrst[obcd_pkg::OBCD_CR_SLOW_SYSBLK];
			clkmon_ff   <= !raw_ff.clkrst[obcd_pkg::OBCD_CR_CLKMON_DIS];
			mult_ff     <= raw_ff.clkrst[obcd_pkg::OBCD_CR_LOOP_SEL]
			             ? obcd_pkg::OBCD_MULT_SIX : obcd_pkg::OBCD_MULT_EIGHT;
			fast4_ff    <= raw_ff.clkrst[obcd_pkg::OBCD_CR_FAST_4M];
			// debug mode from bits 7 and 0; the prohibited code leaves debug off
			unique case ({raw_ff.debug[obcd_pkg::OBCD_DBG_EN_BIT],
			              raw_ff.debug[obcd_pkg::OBCD_DBG_KEEP_BIT]})
				obcd_pkg::OBCD_DBG_ERASE: begin
					dbg_en_ff    <= 1'b1;
					dbg_erase_ff <= 1'b1;
				end
				obcd_pkg::OBCD_DBG_KEEP: begin
					dbg_en_ff    <= 1'b1;
					dbg_erase_ff <= 1'b0;
				end
				obcd_pkg::OBCD_DBG_OFF,
				obcd_pkg::OBCD_DBG_BAD: begin
					dbg_en_ff    <= 1'b0;
					dbg_erase_ff <= 1'b0;
				end
			endcase
			// output source and divider from the five-bit field
			co_src_ff   <= raw_ff.clkout[4:3];
			co_exp_ff   <= (raw_ff.clkout[4:3] == obcd_pkg::OBCD_SRC_MAIN ||
			                raw_ff.clkout[4:3] == obcd_pkg::OBCD_SRC_LOOP)
			             ? obcd_div_exp(raw_ff.clkout[2:0]) : 4'h0;
			// undivided loop clock is refused; default output takes main only
			co_valid_ff <= !(raw_ff.clkout[4:0] == 5'h17) &&
			               (raw_ff.clkout[obcd_pkg::OBCD_CO_DEF_DIS] ||
			                raw_ff.clkout[4:3] == obcd_pkg::OBCD_SRC_MAIN);
		end
	end

	// status flags, captured at commit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_ff <= '0;
		end else if (state_ff == OBCD_ST_COMMIT) begin
			status_ff.load_done        <= 1'b1;
			status_ff.swap_used        <= swap_ff;
			status_ff.clkout_sel_bad   <= (raw_ff.clkout[4:0] == 5'h17) ||
			                              (!raw_ff.clkout[obcd_pkg::OBCD_CO_DEF_DIS] &&
			                               raw_ff.clkout[4:3] != obcd_pkg::OBCD_SRC_MAIN);
			status_ff.clkout_fixed_bad <= raw_ff.clkout[obcd_pkg::OBCD_CO_FIXED_LSB +: 2]
			                              != obcd_pkg::OBCD_CO_FIXED_VAL;
			status_ff.debug_prohibited <= {raw_ff.debug[obcd_pkg::OBCD_DBG_EN_BIT],
			                               raw_ff.debug[obcd_pkg::OBCD_DBG_KEEP_BIT]}
			                              == obcd_pkg::OBCD_DBG_BAD;
			status_ff.debug_fixed_bad  <= raw_ff.debug[6:1] != obcd_pkg::OBCD_DBG_FIXED_VAL;
		end
	end

	// control register: commit loads defaults, software may change them later
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_ff <= obcd_pkg::OBCD_BYTE_RST;
		end else if (state_ff == OBCD_ST_COMMIT) begin
			ctrl_ff[obcd_pkg::OBCD_CTRL_VDET_RUN]  <=
				!raw_ff.clkrst[obcd_pkg::OBCD_CR_VDET_OFF];
			ctrl_ff[obcd_pkg::OBCD_CTRL_CLKOUT_EN] <=
				!raw_ff.clkout[obcd_pkg::OBCD_CO_DEF_DIS];
			ctrl_ff[obcd_pkg::OBCD_CTRL_LATCH]     <= 1'b0;
		end else if (wr_take && bus_idx == obcd_pkg::OBCD_IDX_CTRL && done_ff) begin
			ctrl_ff <= {5'h00, avs_writedata[2:0]};
		end
	end

	// live controls that follow modes and software bits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wdt_cnt_en_ff <= 1'b0;
			slow_run_ff   <= 1'b0;
			vdet_en_ff    <= 1'b0;
			pin_ff        <= 1'b0;
		end else if (done_ff) begin
			// in HALT or STOP the watchdog counts only with the standby bit
			wdt_cnt_en_ff <= !(halt_mode || stop_mode) || wdt_stby_ff;
			slow_run_ff   <= opt_ff.clkrst[obcd_pkg::OBCD_CR_SLOW_EN] &&
			                 (!stop_mode || opt_ff.clkrst[obcd_pkg::OBCD_CR_SLOW_STOP]);
			vdet_en_ff    <= ctrl_ff[obcd_pkg::OBCD_CTRL_VDET_RUN];
			// reset output goes high, port mode drives the latch
			pin_ff        <= opt_ff.clkrst[obcd_pkg::OBCD_CR_PIN_FUNC]
			               ? ctrl_ff[obcd_pkg::OBCD_CTRL_LATCH] : 1'b1;
		end
	end

	// pick the tick of the selected output source
	always_comb begin
		co_tick = 1'b0;
		unique case (co_src_ff)
			obcd_pkg::OBCD_SRC_MAIN: co_tick = main_tick;
			obcd_pkg::OBCD_SRC_LOOP: co_tick = loop_tick;
			obcd_pkg::OBCD_SRC_SLOW: co_tick = slow_tick;
			obcd_pkg::OBCD_SRC_SUB:  co_tick = sub_tick;
		endcase
	end

	// enable bit, or programming mode with default output, keeps it running
	assign co_run = done_ff && co_valid_ff &&
	                (ctrl_ff[obcd_pkg::OBCD_CTRL_CLKOUT_EN] ||
	                 (flash_prog_mode && !opt_ff.clkout[obcd_pkg::OBCD_CO_DEF_DIS]));

	// output clock divider; counter clears whenever output stops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			co_cnt_ff <= 14'h0000;
			co_pin_ff <= 1'b0;
		end else if (!co_run) begin
			// selection is fixed while running, so a change never glitches
			co_cnt_ff <= 14'h0000;
			co_pin_ff <= 1'b0;
		end else begin
			if (co_tick) begin
				co_cnt_ff <= co_cnt_ff + 14'h0001;
			end
			co_pin_ff <= co_cnt_ff[co_exp_ff];
		end
	end

	// register read mux; unmapped indices read zero
	always_comb begin
		nxt_readdata = 32'h0000_0000;
		unique case (bus_idx)
			obcd_pkg::OBCD_IDX_CTRL:   nxt_readdata[7:0] = ctrl_ff;
			obcd_pkg::OBCD_IDX_STATUS: nxt_readdata[7:0] = status_ff;
			obcd_pkg::OBCD_IDX_WDT:    nxt_readdata[7:0] = opt_ff.wdt;
			obcd_pkg::OBCD_IDX_CLKRST: nxt_readdata[7:0] = opt_ff.clkrst;
			obcd_pkg::OBCD_IDX_CLKOUT: nxt_readdata[7:0] = opt_ff.clkout;
			obcd_pkg::OBCD_IDX_DEBUG:  nxt_readdata[7:0] = opt_ff.debug;
			default:                   nxt_readdata      = 32'h0000_0000;
		endcase
	end

	// avalon slave: one wait cycle, then waitrequest low for one cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			waitreq_ff  <= 1'b1;
			readdata_ff <= 32'h0000_0000;
		end else if (!waitreq_ff) begin
			waitreq_ff  <= 1'b1;
		end else if (avs_read || avs_write) begin
			waitreq_ff  <= 1'b0;
			readdata_ff <= avs_read ? nxt_readdata : 32'h0000_0000;
		end
	end

	assign mem_rd_req                  = mem_rd_req_ff;
	assign mem_addr                    = mem_addr_ff;
	assign avs_readdata                = readdata_ff;
	assign avs_waitrequest             = waitreq_ff;
	assign cfg_done                    = done_ff;
	assign wdt_count_enable            = wdt_cnt_en_ff;
	assign watchdog_standby_run        = wdt_stby_ff;
	assign watchdog_window             = wdt_win_ff;
	assign slow_osc_run                = slow_run_ff;
	assign slow_osc_sysclk_allowed     = slow_sys_ff;
	assign clock_monitor_enable        = clkmon_ff;
	assign shared_output_pin           = pin_ff;
	assign loop_multiplier             = mult_ff;
	assign fast_osc_4mhz               = fast4_ff;
	assign low_voltage_detector_enable = vdet_en_ff;
	assign clock_output_pin            = co_pin_ff;
	assign debug_enable                = dbg_en_ff;
	assign debug_erase_on_fail         = dbg_erase_ff;

endmodule

// ==== obcd_decoder_sva.sv ====
// checker: concurrent properties on the option byte decoder ports
`timescale 1ns/1ps

module obcd_decoder_chk (
	input logic                                 clk,
	input logic                                 reset_n,
	input logic                                 halt_mode,
	input logic                                 stop_mode,
	input logic                                 mem_rd_req,
	input logic [obcd_pkg::OBCD_MEM_ADDR_W-1:0] mem_addr,
	input logic                                 cfg_done,
	input logic                                 wdt_count_enable,
	input logic                                 watchdog_standby_run,
	input logic [1:0]                           watchdog_window,
	input logic                                 shared_output_pin,
	input logic [3:0]                           loop_multiplier,
	input logic                                 debug_enable,
	input logic                                 debug_erase_on_fail
);
	// one clock domain, one reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_safe_until_done: assert property (!cfg_done |-> loop_multiplier == 4'h8 &&
		watchdog_window == 2'h3 && !debug_enable && !shared_output_pin)
		else $error("outputs left safe state before load");
	a_window_full_open: assert property (cfg_done && !watchdog_standby_run |->
		watchdog_window == 2'h3) else $error("window not full with standby clear");
	a_wdt_standby_run: assert property (cfg_done && $past(cfg_done) && watchdog_standby_run
		|-> wdt_count_enable) else $error("watchdog stopped with standby set");
	a_wdt_halt_stop: assert property (cfg_done && $past(cfg_done) && !watchdog_standby_run
		&& ($past(halt_mode) || $past(stop_mode)) |-> !wdt_count_enable)
		else $error("watchdog ran in halt or stop");
	a_debug_no_erase: assert property (!debug_enable |-> !debug_erase_on_fail)
		else $error("erase policy without debug");
	a_fetch_base_ok: assert property (mem_rd_req |->
		mem_addr[19:2] == obcd_pkg::OBCD_BASE_PRIMARY[19:2] ||
		mem_addr[19:2] == obcd_pkg::OBCD_BASE_SWAP[19:2]) else $error("fetch address off");
	a_fetch_last_byte: assert property ($rose(cfg_done) |-> mem_addr[1:0] == 2'h3)
		else $error("commit before fourth byte");
	a_req_one_cycle: assert property (mem_rd_req |=> !mem_rd_req)
		else $error("read strobe longer than one cycle");
	a_mult_legal: assert property (cfg_done |-> loop_multiplier == 4'h8 ||
		loop_multiplier == 4'h6) else $error("multiplier value illegal");

	// main scenarios reached
	c_load_done: cover property ($rose(cfg_done));
	c_swap_fetch: cover property (mem_rd_req && mem_addr[13]);
	c_erase_mode: cover property ($rose(debug_erase_on_fail));
endmodule

bind obcd_decoder obcd_decoder_chk u_obcd_decoder_chk (.clk, .reset_n, .halt_mode, .stop_mode,
	.mem_rd_req, .mem_addr, .cfg_done, .wdt_count_enable, .watchdog_standby_run,
	.watchdog_window, .shared_output_pin, .loop_multiplier, .debug_enable,
	.debug_erase_on_fail);

// ==== option_byte_config_decoder_tb.sv ====
// testbench: option byte loads, decode table, register bus and clock output
`timescale 1ns/1ps

module option_byte_config_decoder_tb;
	logic clk = 0, reset_n = 0, boot_swap = 0, halt_mode = 1, stop_mode = 1;
	logic flash_prog_mode = 0, main_tick = 0, loop_tick = 0, mem_rd_valid = 0;
	logic avs_read = 0, avs_write = 0, v1 = 0;
	logic [7:0] mem_rd_data = 8'h00;
	logic [9:0] avs_address = 10'h000;
	logic [31:0] avs_writedata = 32'h0000_0000, ob = 32'h0000_0000, q;
	logic [19:0] a1 = 20'h0_0000, mem_addr;
	logic mem_rd_req, avs_waitrequest, cfg_done, wdt_count_enable, watchdog_standby_run;
	logic slow_osc_run, slow_osc_sysclk_allowed, clock_monitor_enable, shared_output_pin;
	logic fast_osc_4mhz, low_voltage_detector_enable, clock_output_pin, debug_enable;
	logic debug_erase_on_fail;
	logic [1:0] watchdog_window;
	logic [3:0] loop_multiplier;
	logic [31:0] avs_readdata;
	int err_count = 0, n_checks = 0, cyc = 0, t;
	// four configurations {debug, clkout, clkrst, wdt}; the third carries the prohibited debug code
	logic [31:0] cfgs [0:3] = '{32'h857f_c936, 32'h04ff_3641, 32'h05ff_7f00, 32'h84f6_8021};

	obcd_decoder u_obcd_decoder (.clk, .reset_n, .boot_swap, .halt_mode, .stop_mode,
		.flash_prog_mode, .main_tick, .loop_tick, .slow_tick(1'b0), .sub_tick(1'b0),
		.mem_rd_req, .mem_addr, .mem_rd_data, .mem_rd_valid, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
		.cfg_done, .wdt_count_enable, .watchdog_standby_run, .watchdog_window, .slow_osc_run,
		.slow_osc_sysclk_allowed, .clock_monitor_enable, .shared_output_pin, .loop_multiplier,
		.fast_osc_4mhz, .low_voltage_detector_enable, .clock_output_pin, .debug_enable,
		.debug_erase_on_fail);

	// 250 MHz clock
	always #2 clk = ~clk;

	// flash model: answers two cycles after each strobe, scrambles data between answers
	always @(posedge clk) begin
		v1 <= mem_rd_req;
		a1 <= mem_addr;
		mem_rd_valid <= v1;
		mem_rd_data <= v1 ? ob[8*a1[1:0] +: 8] : ~mem_rd_data;
		main_tick <= ~main_tick;
		loop_tick <= main_tick;
		if (v1) check(a1 & 20'hf_fffc, boot_swap ? 20'h0_20c0 : 20'h0_00c0);
	end

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// reset for 20 cycles, then wait for the load to commit
	task automatic load(input logic [31:0] cfg, input logic sw);
		@(posedge clk);
		reset_n <= 1'b0;
		boot_swap <= sw;
		ob <= cfg;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		while (cfg_done !== 1'b1) @(posedge clk);
		repeat (3) @(posedge clk);
	endtask

	task automatic decode(input logic [31:0] cfg, input logic sw);
		logic [7:0] w, c, d;
		w = cfg[7:0];
		c = cfg[15:8];
		d = cfg[31:24];
		load(cfg, sw);
		check(watchdog_standby_run, w[0]);
		check(wdt_count_enable, w[0]);
		check(watchdog_window, w[0] ? w[6:5] : 2'h3);
		check(slow_osc_run, c[7] & c[6]);
		check(slow_osc_sysclk_allowed, !c[5]);
		check(clock_monitor_enable, !c[4]);
		check(shared_output_pin, !c[3]);
		check(loop_multiplier, c[2] ? 4'h6 : 4'h8);
		check(fast_osc_4mhz, c[1]);
		check(low_voltage_detector_enable, !c[0]);
		check(debug_enable, d[7]);
		check(debug_erase_on_fail, d[7] & !d[0]);
		bus(1'b0, 10'h304, 32'h0000_0000);
		check(q, c);
		bus(1'b0, 10'h004, 32'h0000_0000);
		check(q[1:0], {sw, 1'b1});
		check(q[4], !d[7] & d[0]);
	endtask

	task automatic toggles();
		logic p;
		t = 0;
		p = clock_output_pin;
		repeat (40) begin
			@(posedge clk);
			if (clock_output_pin !== p) t++;
			p = clock_output_pin;
		end
	endtask

	// config 0: port latch, halt and stop, clock output on/off, read-only and unmapped places
	task automatic regs();
		bus(1'b1, 10'h000, 32'h0000_0006);
		repeat (2) @(posedge clk);
		check(shared_output_pin, 1);
		halt_mode <= 1'b0;
		stop_mode <= 1'b0;
		repeat (2) @(posedge clk);
		check(wdt_count_enable, 1);
		stop_mode <= 1'b1;
		repeat (2) @(posedge clk);
		check(wdt_count_enable, 0);
		halt_mode <= 1'b1;
		toggles();
		check(t >= 18, 1);
		bus(1'b1, 10'h000, 32'h0000_0004);
		repeat (4) @(posedge clk);
		toggles();
		check(t, 0);
		flash_prog_mode <= 1'b1;
		toggles();
		check(t >= 18, 1);
		flash_prog_mode <= 1'b0;
		bus(1'b1, 10'h304, 32'h0000_0000);
		bus(1'b0, 10'h304, 32'h0000_0000);
		check(q, 32'h0000_00c9);
		bus(1'b0, 10'h200, 32'h0000_0000);
		check(q, 0);
	endtask

	// detector run bit cleared, restored by a new reset; then loop clock halved and STOP left
	task automatic vdet();
		bus(1'b1, 10'h000, 32'h0000_0000);
		repeat (3) @(posedge clk);
		check(low_voltage_detector_enable, 0);
		load(cfgs[3], 1'b1);
		check(low_voltage_detector_enable, 1);
		bus(1'b1, 10'h000, 32'h0000_0002);
		toggles();
		check(t >= 8 && t <= 10, 1);
		stop_mode <= 1'b0;
		repeat (2) @(posedge clk);
		check(slow_osc_run, 1);
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		decode(cfgs[0], 1'b0);
		regs();
		for (int i = 1; i < 4; i++) decode(cfgs[i], i[0]);
		vdet();
		test_done();
	end
endmodule
